// >>> rtl/ofm_top.sv
// Output fault monitor: Wishbone registers, pulse scheduler, fault flags, lamps and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ofm_map.svh"

module ofm_top #(
    parameter int PULSE_CYC = `OFM_PULSE_CYC,
    parameter int SLOTS = `OFM_SLOTS_PER_REPEAT,
    parameter int BLINK_SLOTS = `OFM_BLINK_SLOTS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ofm_pkg::ofm_wb_req_t wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire ofm_pkg::ofm_sense_t sense_i,
    input wire logic [1:0] full_test_sw_i,
    output logic [15:0] drv_o,
    output logic [1:0] lamp_o,
    output logic irq_o
);
    import ofm_pkg::*;

    localparam int NPT = 16;
    localparam int GSZ = 8;
    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam int SW = $clog2(SLOTS + 1);
    localparam int BW = $clog2(BLINK_SLOTS + 1);

    logic [PW-1:0] pre_cnt;
    logic slot_tick;
    logic [SW-1:0] slot_cnt;
    logic [BW-1:0] blink_cnt;
    logic blink_phase;
    logic [NPT-1:0] pulse_mask;
    logic [NPT-1:0] full_mask;
    logic [NPT-1:0] cmd;
    logic word_map;
    logic cmd_seen;
    logic [1:0] irq_sts;
    logic [1:0] irq_msk;
    logic [NPT-1:0] open_flags;
    logic [NPT-1:0] short_flags;
    logic [NPT-1:0] open_set;
    logic [NPT-1:0] short_set;
    logic [NPT-1:0] next_drv;
    logic wb_hit;
    logic wr_take;
    logic cmd_wr;
    logic [NPT-1:0] view_cmd;
    logic [NPT-1:0] view_new;
    logic [NPT-1:0] next_cmd;
    logic [NPT-1:0] lane_view;
    logic [NPT-1:0] lane_mask;
    logic [31:0] rd_mux;

    // Bit order reversal used by word mapping
    function automatic logic [15:0] ofm_rev(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    // Software view of a point vector; word mapping puts point 16 at bit 0
    function automatic logic [15:0] ofm_view(input logic wm, input logic [15:0] v);
        return wm ? ofm_rev(v) : v;
    endfunction

    // Prescaler: one tick every pulse width
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_cnt <= '0;
            slot_tick <= 1'b0;
        end else if (pre_cnt == PW'(PULSE_CYC - 1)) begin
            pre_cnt <= '0;
            slot_tick <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
            slot_tick <= 1'b0;
        end
    end

    // Slot counter: one repeat period is SLOTS ticks, points pulse in slots 0 to 15
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_cnt <= '0;
        end else if (slot_tick) begin
            if (slot_cnt == SW'(SLOTS - 1)) begin
                slot_cnt <= '0;
            end else begin
                slot_cnt <= slot_cnt + 1'b1;
            end
        end
    end

    // Lamp blink phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt <= '0;
            blink_phase <= 1'b0;
        end else if (slot_tick) begin
            if (blink_cnt == BW'(BLINK_SLOTS - 1)) begin
                blink_cnt <= '0;
                blink_phase <= ~blink_phase;
            end else begin
                blink_cnt <= blink_cnt + 1'b1;
            end
        end
    end

    // Per-point pulse select, gated by its group switch
    always_comb begin
        for (int p = 0; p < NPT; p++) begin
            full_mask[p] = full_test_sw_i[p / GSZ];
            pulse_mask[p] = full_mask[p] && (slot_cnt == SW'(p));
        end
    end

    // Wishbone decode; a write takes effect on the edge that sees ack
    assign wb_hit = wb_req_i.cyc & wb_req_i.stb;
    assign wr_take = wb_hit & wb_req_i.we & wb_ack_o;
    assign cmd_wr = wr_take && (wb_req_i.adr == `OFM_ADR_CMD) && (wb_req_i.sel[1:0] != 2'h0);

    // Byte-lane merge of the command word in the software view
    always_comb begin
        view_cmd = ofm_view(word_map, cmd);
        lane_view = {{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
        view_new = (wb_req_i.dat[15:0] & lane_view) | (view_cmd & ~lane_view);
        next_cmd = ofm_view(word_map, view_new);
        lane_mask = cmd_wr ? ofm_view(word_map, lane_view) : 16'h0000;
    end

    // Command word and first-command flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd <= `OFM_CMD_RST;
            cmd_seen <= 1'b0;
        end else if (cmd_wr) begin
            cmd <= next_cmd;
            cmd_seen <= 1'b1;
        end
    end

    // Control: word mapping select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_map <= `OFM_CTRL_RST;
        end else if (wr_take && wb_req_i.adr == `OFM_ADR_CTRL && wb_req_i.sel[0]) begin
            word_map <= wb_req_i.dat[`OFM_CTRL_WORD_MAP];
        end
    end

    // Point instances
    genvar gp;
    generate
        for (gp = 0; gp < NPT; gp++) begin : g_pt
            ofm_point u_pt (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .full_i(full_mask[gp]),
                .pulse_i(pulse_mask[gp]),
                .cmd_i(cmd[gp]),
                .cmd_wr_i(lane_mask[gp]),
                .cmd_new_i(next_cmd[gp]),
                .drv_i(drv_o[gp]),
                .open_sense_i(sense_i.open_load[gp]),
                .short_sense_i(sense_i.over_current[gp]),
                .drv_next_o(next_drv[gp]),
                .open_flag_o(open_flags[gp]),
                .short_flag_o(short_flags[gp]),
                .open_set_o(open_set[gp]),
                .short_set_o(short_set[gp])
            );
        end
    endgenerate

    // Field drive register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_o <= 16'h0000;
        end else begin
            drv_o <= next_drv;
        end
    end

    // Group lamps blink while a fault stands, dark until the first command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lamp_o <= 2'h0;
        end else begin
            for (int g = 0; g < 2; g++) begin
                lamp_o[g] <= cmd_seen & blink_phase &
                    (|open_flags[g*GSZ +: GSZ] | |short_flags[g*GSZ +: GSZ]);
            end
        end
    end

    // Interrupt status: sticky, write one to clear, a new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_sts <= `OFM_IRQ_RST;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (wr_take && wb_req_i.adr == `OFM_ADR_IRQ_STS && wb_req_i.sel[0] && wb_req_i.dat[b]) begin
                    irq_sts[b] <= 1'b0;
                end
            end
            if (|open_set) begin
                irq_sts[`OFM_IRQ_OPEN] <= 1'b1;
            end
            if (|short_set) begin
                irq_sts[`OFM_IRQ_SHORT] <= 1'b1;
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_msk <= `OFM_IRQ_RST;
        end else if (wr_take && wb_req_i.adr == `OFM_ADR_IRQ_MSK && wb_req_i.sel[0]) begin
            irq_msk <= wb_req_i.dat[1:0];
        end
    end

    // Interrupt output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_sts & irq_msk);
        end
    end

    // Read multiplexer; the second holding word and unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_req_i.adr)
            `OFM_ADR_CMD: rd_mux[15:0] = view_cmd;
            `OFM_ADR_HOLD2: rd_mux = 32'h0000_0000;
            `OFM_ADR_OPEN: rd_mux[15:0] = ofm_view(word_map, open_flags);
            `OFM_ADR_SHORT: rd_mux[15:0] = ofm_view(word_map, short_flags);
            `OFM_ADR_CTRL: rd_mux[`OFM_CTRL_WORD_MAP] = word_map;
            `OFM_ADR_IRQ_STS: rd_mux[1:0] = irq_sts;
            `OFM_ADR_IRQ_MSK: rd_mux[1:0] = irq_msk;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus answer: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit & ~wb_ack_o;
            if (wb_hit && !wb_ack_o) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wb_req;
        wb_hit && !wb_ack_o;
    endsequence

    sequence s_wb_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_wb_answer: assert property (s_wb_req |=> s_wb_ack)
        else $error("bus request not answered by a single-cycle ack");
    a_short_off: assert property (short_flags[0] || short_set[0] |=> !drv_o[0])
        else $error("shorted point 0 still driven");
    a_short_any: assert property (|(short_flags & drv_o) == 1'b0)
        else $error("current flows through a flagged short");
    a_open_catch: assert property ((|(~drv_o & sense_i.open_load)) |=>
        ((open_flags & $past(~drv_o & sense_i.open_load)) == $past(~drv_o & sense_i.open_load)))
        else $error("open load in off state not flagged");
    a_short_catch: assert property ((|(drv_o & sense_i.over_current)) |=>
        ((short_flags & $past(drv_o & sense_i.over_current)) == $past(drv_o & sense_i.over_current)))
        else $error("over current in on state not flagged");
    a_pulse_gate: assert property ($onehot0(pulse_mask) && ((pulse_mask & ~full_mask) == 16'h0000))
        else $error("pulse on a point whose group switch is off");
    a_pulse_inv: assert property (pulse_mask[1] && !short_flags[1] && !short_set[1] |=> drv_o[1] == !$past(cmd[1]))
        else $error("test pulse did not invert the command");
    a_lamp_dark: assert property (!(|open_flags) && !(|short_flags) |=> lamp_o == 2'h0)
        else $error("lamp lit without a fault");
    a_reset_clean: assert property ($past(rst_i) |-> drv_o == 16'h0000 && open_flags == 16'h0000 && lamp_o == 2'h0)
        else $error("state not clean after reset");
    a_irq_level: assert property (!$past(rst_i) |-> irq_o == $past(|(irq_sts & irq_msk)))
        else $error("interrupt output does not follow masked status");
endmodule

`default_nettype wire

// >>> common/ofm_map.svh
// Register offsets, field positions, reset values and timing counts of the output fault monitor
// Notes on behaviour
// - Two fault tests, pulsed full test and unpulsed partial test, chosen per group.
// - Partial test checks open only while a point is off, short only while on.
// - Full test briefly drives each output opposite to its command to check both states.
// - The opposite-state pulse lasts 500 us and repeats once a second per point.
// - Host sees two input words plus two holding words, or 32 outputs plus 32 inputs.
// - An open circuit on point n sets bit n of the first input word.
// - A short circuit on point n sets bit n of the second input word.
// - Fault words read one for a fault, zero for normal operation.
// - Only three words are used; the second holding word is ignored.
// - A point found shorted carries no more output current.
// - Outside full test, a command changing state clears that point's reported faults.
// - In both modes a detected short forces the point off whatever the command.
// - A group's fault lamp blinks while any point in it holds a fault; the code keeps it dark until the first command write after reset.
// - Partial test: writing a one to a command bit clears its open flag.
// - Partial test: writing a zero to a command bit clears its short flag.
// - A per-group switch enables pulsing of its eight points; off means no pulse test.
// - In word mapping, output point 16 is the least significant bit of word one.
`ifndef OFM_MAP_SVH
`define OFM_MAP_SVH

// Wishbone byte addresses
`define OFM_ADR_CMD 8'h00
`define OFM_ADR_HOLD2 8'h04
`define OFM_ADR_OPEN 8'h08
`define OFM_ADR_SHORT 8'h0C
`define OFM_ADR_CTRL 8'h10
`define OFM_ADR_IRQ_STS 8'h14
`define OFM_ADR_IRQ_MSK 8'h18

// Field positions
`define OFM_CTRL_WORD_MAP 0
`define OFM_IRQ_OPEN 0
`define OFM_IRQ_SHORT 1

// Reset values
`define OFM_CMD_RST 16'h0000
`define OFM_FLAGS_RST 16'h0000
`define OFM_CTRL_RST 1'b0
`define OFM_IRQ_RST 2'h0

// Timing: clock rate, pulse width, repeat period and lamp half period
`define OFM_CLK_MHZ 250
`define OFM_PULSE_US 500
`define OFM_REPEAT_US 1000000
`define OFM_PULSE_CYC (`OFM_PULSE_US * `OFM_CLK_MHZ)
`define OFM_SLOTS_PER_REPEAT (`OFM_REPEAT_US / `OFM_PULSE_US)
`define OFM_BLINK_SLOTS (`OFM_SLOTS_PER_REPEAT / 4)

`endif

// >>> common/ofm_pkg.sv
// Types shared by the output fault monitor files
package ofm_pkg;

    // Classic Wishbone request from the bus master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } ofm_wb_req_t;

    // Load sense from the field side, one bit per point
    typedef struct packed {
        logic [15:0] open_load;
        logic [15:0] over_current;
    } ofm_sense_t;

endpackage

// >>> rtl/ofm_point.sv
// One output point: drive select, open and short fault flags
`timescale 1ns/1ps
`default_nettype none

module ofm_point (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic full_i,
    input wire logic pulse_i,
    input wire logic cmd_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_new_i,
    input wire logic drv_i,
    input wire logic open_sense_i,
    input wire logic short_sense_i,
    output logic drv_next_o,
    output logic open_flag_o,
    output logic short_flag_o,
    output logic open_set_o,
    output logic short_set_o
);
    logic clr_open;
    logic clr_short;

    // Open is seen only in the driven-off state, short only in the on state
    assign open_set_o = ~drv_i & open_sense_i & ~open_flag_o;
    assign short_set_o = drv_i & short_sense_i & ~short_flag_o;

    // Full test clears on a written zero; partial test clears open on a one, short on a zero, both on a change
    always_comb begin
        if (full_i) begin
            clr_open = cmd_wr_i & ~cmd_new_i;
            clr_short = cmd_wr_i & ~cmd_new_i;
        end else begin
            clr_open = cmd_wr_i & (cmd_new_i | (cmd_new_i ^ cmd_i));
            clr_short = cmd_wr_i & (~cmd_new_i | (cmd_new_i ^ cmd_i));
        end
    end

    // Flags: a new fault wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            open_flag_o <= 1'b0;
            short_flag_o <= 1'b0;
        end else begin
            open_flag_o <= open_set_o | (open_flag_o & ~clr_open);
            short_flag_o <= short_set_o | (short_flag_o & ~clr_short);
        end
    end

    // Shorted point is off; a test pulse inverts the command
    assign drv_next_o = ~(short_flag_o | short_set_o) & (pulse_i ? ~cmd_i : cmd_i);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_clear_open_one: assert property (cmd_wr_i && cmd_new_i && !full_i && !open_set_o |=> !open_flag_o)
        else $error("open flag survived a partial-mode write of one");
    a_clear_short_zero: assert property (cmd_wr_i && !cmd_new_i && !full_i && !short_set_o |=> !short_flag_o)
        else $error("short flag survived a partial-mode write of zero");
endmodule

`default_nettype wire

// >>> test/ofm_load_model.sv
// Field load model for the output fault monitor bench
`timescale 1ns/1ps
`default_nettype none

module ofm_load_model (
    input wire logic [15:0] drv_i,
    input wire logic [15:0] open_mask_i,
    input wire logic [15:0] short_mask_i,
    output var ofm_pkg::ofm_sense_t sense_o
);
    import ofm_pkg::*;

    // An open load only shows while off, an overload only while driven on
    always_comb begin
        sense_o.open_load = ~drv_i & open_mask_i;
        sense_o.over_current = drv_i & short_mask_i;
    end
endmodule

`default_nettype wire

// >>> test/ofm_top_bench.sv
// Self-checking bench for the output fault monitor
`timescale 1ns/1ps
`default_nettype none
`include "ofm_map.svh"

module ofm_top_bench;
    import ofm_pkg::*;
    localparam int PC = 4;
    localparam int SL = 20;
    localparam logic [31:0] Z = 32'h0000_0000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ofm_wb_req_t req = '0;
    ofm_sense_t sense;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [1:0] sw = 2'b00;
    logic [15:0] drv_o;
    logic [1:0] lamp_o;
    logic irq_o;
    logic [15:0] open_m = 16'h0000;
    logic [15:0] short_m = 16'h0000;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 54;

    // Clock at 250 MHz
    always #2 clk_i = ~clk_i;

    ofm_top #(.PULSE_CYC(PC), .SLOTS(SL), .BLINK_SLOTS(2)) ofm_top_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_req_i(req),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .sense_i(sense),
        .full_test_sw_i(sw),
        .drv_o(drv_o),
        .lamp_o(lamp_o),
        .irq_o(irq_o)
    );

    ofm_load_model ofm_load_model_inst (
        .drv_i(drv_o),
        .open_mask_i(open_m),
        .short_mask_i(short_m),
        .sense_o(sense)
    );

    // Verdict and end of run
    task automatic final_report();
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Counts one comparison and reports a difference
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Expected software view of a point vector under word mapping
    function automatic logic [15:0] exp_rev(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    // One classic Wishbone cycle, held until ack is sampled high; only the watchdog ends a hang
    task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d, output logic [31:0] q);
        @(posedge clk_i);
        chk("ack idle", Z, {31'h0000_0000, wb_ack_o});
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: {16'h0000, d}};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        wb(a, 1'b0, 16'h0000, q);
        chk(what, exp, q);
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        tick(20000);
        n_mismatch++;
        final_report();
    end

    // Main sequence
    initial begin
        logic [15:0] c;
        int p, q, hi, lo, l1;
        int cnt[16];
        tick(12);
        rst_i <= 1'b0;
        tick(1);
        chk("drv reset", Z, {16'h0000, drv_o});
        chk("lamp irq reset", Z, {29'h0000_0000, lamp_o, irq_o});
        for (int a = 0; a < 7; a++) rd(8'(a * 4), Z, "reg reset");
        // Random commands with the unused word written in between
        for (int i = 0; i < 8; i++) begin
            c = 16'($random(seed));
            wr(`OFM_ADR_CMD, c);
            wr(`OFM_ADR_HOLD2, ~c);
            tick(2);
            chk("drv", {16'h0000, c}, {16'h0000, drv_o});
            rd(`OFM_ADR_CMD, {16'h0000, c}, "cmd");
            rd(`OFM_ADR_HOLD2, Z, "hold2");
        end
        rd(8'h40, Z, "unmapped");
        // Reversed bit order in word mapping
        wr(`OFM_ADR_CTRL, 16'h0001);
        wr(`OFM_ADR_CMD, 16'h0001);
        tick(2);
        chk("drv map", 32'h0000_8000, {16'h0000, drv_o});
        rd(`OFM_ADR_CMD, 32'h0000_0001, "cmd map");
        c = 16'($random(seed));
        wr(`OFM_ADR_CMD, c);
        tick(2);
        chk("drv map rand", {16'h0000, exp_rev(c)}, {16'h0000, drv_o});
        rd(`OFM_ADR_CMD, {16'h0000, c}, "cmd map rand");
        wr(`OFM_ADR_CTRL, 16'h0000);
        wr(`OFM_ADR_CMD, 16'h0000);
        // Open load on an off point, overload on an off point is ignored
        p = {$random(seed)} % 8;
        q = 8 + {$random(seed)} % 8;
        open_m <= 16'(1 << p);
        short_m <= 16'(1 << q);
        tick(4);
        rd(`OFM_ADR_OPEN, 32'(1 << p), "open");
        rd(`OFM_ADR_SHORT, Z, "short off");
        rd(`OFM_ADR_IRQ_STS, 32'h0000_0001, "irq sts");
        wr(`OFM_ADR_IRQ_MSK, 16'h0003);
        tick(2);
        chk("irq", 32'h0000_0001, {31'h0000_0000, irq_o});
        hi = 0;
        lo = 0;
        l1 = 0;
        for (int i = 0; i < 40; i++) begin
            tick(1);
            hi += (lamp_o[0] === 1'b1);
            lo += (lamp_o[0] === 1'b0);
            l1 += (lamp_o[1] !== 1'b0);
        end
        chk("lamp blink", 32'h0000_0001, 32'(hi > 0 && lo > 0));
        chk("lamp other", Z, 32'(l1));
        wr(`OFM_ADR_IRQ_STS, 16'h0001);
        tick(2);
        chk("irq clear", Z, {31'h0000_0000, irq_o});
        // Writing one clears open, driving into a short forces the point off
        open_m <= 16'h0000;
        tick(1);
        wr(`OFM_ADR_CMD, 16'((1 << p) | (1 << q)));
        tick(4);
        rd(`OFM_ADR_OPEN, Z, "open clear");
        rd(`OFM_ADR_SHORT, 32'(1 << q), "short");
        chk("drv short", 32'(1 << p), {16'h0000, drv_o});
        chk("irq short", 32'h0000_0001, {31'h0000_0000, irq_o});
        wr(`OFM_ADR_CMD, 16'(1 << p));
        tick(3);
        rd(`OFM_ADR_SHORT, Z, "short clear");
        wr(`OFM_ADR_IRQ_STS, 16'h0003);
        short_m <= 16'h0000;
        wr(`OFM_ADR_CMD, 16'h0000);
        tick(2);
        chk("irq clear2", Z, {31'h0000_0000, irq_o});
        // Pulse test per group over one full period
        for (int s = 1; s < 3; s++) begin
            sw <= 2'(s);
            c = 16'($random(seed));
            wr(`OFM_ADR_CMD, c);
            tick(SL * PC);
            foreach (cnt[i]) cnt[i] = 0;
            repeat (SL * PC) begin
                tick(1);
                for (int i = 0; i < 16; i++) cnt[i] += (drv_o[i] !== c[i]);
            end
            for (int i = 0; i < 16; i++) chk("pulse", 32'(sw[i / 8] ? PC : 0), 32'(cnt[i]));
        end
        // Mid-run reset with every load open: flags set, lamps dark until a command arrives
        sw <= 2'b00;
        open_m <= 16'hFFFF;
        rst_i <= 1'b1;
        tick(3);
        rst_i <= 1'b0;
        tick(1);
        chk("drv reset2", Z, {16'h0000, drv_o});
        l1 = 0;
        repeat (40) begin
            tick(1);
            l1 += (lamp_o !== 2'h0);
        end
        chk("lamp dark", Z, 32'(l1));
        wr(`OFM_ADR_CMD, 16'h0000);
        rd(`OFM_ADR_OPEN, 32'h0000_FFFF, "open kept");
        hi = 0;
        repeat (40) begin
            tick(1);
            hi += (lamp_o === 2'h3);
        end
        chk("lamp lit", 32'h0000_0001, 32'(hi > 0));
        // Full test: a written zero clears the open flags
        open_m <= 16'h0000;
        sw <= 2'b11;
        wr(`OFM_ADR_CMD, 16'h0000);
        rd(`OFM_ADR_OPEN, Z, "open full clear");
        final_report();
    end
endmodule

`default_nettype wire
